// ===== common/conv_seq_params.svh
// Constants for the conversion sequencer: register offsets, field positions, timing counts.
// Assumes inclusion by bare name from the package and the design file.
//
// Summary of operation
// - Eight inputs, one muxed to converter.
// - Standard 8-bit or precision 10-bit result.
// - Pseudo-idle select halts CPU during conversion.
// - Precision mode needs done interrupt enabled; here the halt ends at completion whatever irq_en holds.
// - Other interrupts held until precision conversion ends.
// - Pin config bit set makes pin analog.
// - Start on unconfigured channel does nothing.
// - Conversion is eleven converter clock periods.
// - Done flag polled, optional interrupt.
// - Start bit self-clears at completion.
// - Done flag set on result, software clears.
// - Three-bit field selects input by value.
// - Enable clear means standby, no conversion.
`ifndef CONV_SEQ_PARAMS_SVH
`define CONV_SEQ_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_PIN_CONFIG   3'h0
`define OFS_CONTROL      3'h1
`define OFS_PRESCALE     3'h2
`define OFS_DATA_HIGH    3'h3
`define OFS_DATA_LOW     3'h4
`define OFS_IRQ_ENABLE   3'h5

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTL_PSEUDO_IDLE_SELECT_BIT   6
`define CTL_ENABLE_BIT   5
`define CTL_DONE_BIT     4
`define CTL_START_BIT    3
`define CTL_CH_HI        2
`define CTL_CH_LO        0
`define CTL_RESET        8'h00
`define PRS_RESET        5'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CONV_PERIODS     4'hB
`define STD_BITS         4'h8
`define PRS_BASE_DIV     9'h004
`define SETUP_TIME_NS    4000
`define CLK_PERIOD_NS    8
`define SETUP_CYCLES     ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== common/conv_seq_pkg.sv
// Types for the conversion sequencer.
// Assumes the params header is on the include path.
`default_nettype none
`include "conv_seq_params.svh"

package conv_seq_pkg;
    typedef enum logic [1:0] {
        ST_OFF   = 2'h0,
        ST_IDLE  = 2'h1,
        ST_CONV  = 2'h3
    } seq_state_e;

    typedef struct packed {
        seq_state_e  state;
        logic [7:0]  pin_config;
        logic        pseudo_idle_select;
        logic        enable;
        logic        done;
        logic        start;
        logic [2:0]  channel;
        logic [4:0]  prescale;
        logic        irq_en;
        logic [8:0]  div_cnt;
        logic [3:0]  period_cnt;
        logic [9:0]  shift;
        logic [9:0]  result;
        logic        precision;
        logic [7:0]  rdata;
        logic [7:0]  irq_hold;
        logic [11:0] setup_cnt;
        logic        sample_d1;
        logic        sample_d2;
    } seq_regs_s;
endpackage : conv_seq_pkg
`default_nettype wire

// ===== hw/conv_seq.sv
// Conversion sequencer: register file, prescaler, mux select and bit-by-bit result capture.
// Assumes a synchronous register port on clk and a comparator bit from the analog array.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "conv_seq_params.svh"

module conv_seq (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Register port
    input  wire logic [2:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rdata,
    // Analog front end
    output logic      [7:0]  analog_pin_enable,
    output logic      [2:0]  mux_select,
    output logic             sample_hold,
    output logic      [9:0]  trial_code,
    input  wire logic        comparator_in,
    output logic             converter_powered,
    // CPU and interrupt controller
    input  wire logic [7:0]  other_irq_in,
    output logic      [7:0]  other_irq_out,
    output logic             cpu_halt,
    output logic             conversion_irq,
    output logic             setup_ready
);

    conv_seq_pkg::seq_regs_s r_r;
    conv_seq_pkg::seq_regs_s r_nxt;
    logic                    tick;
    logic                    cmp_sync;
    logic [7:0]              ctl_view;

    // ------------------------------------------------------------
    // Combinational views
    // ------------------------------------------------------------
    assign tick     = (r_r.div_cnt == 9'h000);
    // Only the second synchroniser stage feeds the bit decisions.
    assign cmp_sync = r_r.sample_d2;
    assign ctl_view = {1'b0, r_r.pseudo_idle_select, r_r.enable, r_r.done, r_r.start, r_r.channel};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        r_nxt           = r_r;
        r_nxt.sample_d1 = comparator_in;
        r_nxt.sample_d2 = r_r.sample_d1;
        r_nxt.rdata     = 8'h00;

        // --------------------------------------------------------
        // Register read
        // --------------------------------------------------------
        // Unused offsets read as zero so software can probe the map.
        if (rd_en) begin
            unique case (addr)
                `OFS_PIN_CONFIG: r_nxt.rdata = r_r.pin_config;
                `OFS_CONTROL:    r_nxt.rdata = ctl_view;
                `OFS_PRESCALE:   r_nxt.rdata = {3'h0, r_r.prescale};
                `OFS_DATA_HIGH:  r_nxt.rdata = r_r.result[9:2];
                `OFS_DATA_LOW:   r_nxt.rdata = {6'h00, r_r.result[1:0]};
                `OFS_IRQ_ENABLE: r_nxt.rdata = {7'h00, r_r.irq_en};
                default:         r_nxt.rdata = 8'h00;
            endcase
        end

        // --------------------------------------------------------
        // Prescaler and setup timer
        // --------------------------------------------------------
        // Prescaler runs only while enabled so standby draws no toggling.
        // A new prescale takes effect at the next reload, one period late.
        if (!r_r.enable || tick) begin
            r_nxt.div_cnt = 9'((`PRS_BASE_DIV * ({4'h0, r_r.prescale} + 9'h001)) - 9'h001);
        end else begin
            r_nxt.div_cnt = r_r.div_cnt - 9'h001;
        end

        // The setup count restarts whenever the enable bit is written low.
        if (r_r.enable && r_r.setup_cnt != 12'h000) begin
            r_nxt.setup_cnt = r_r.setup_cnt - 12'h001;
        end

        // --------------------------------------------------------
        // Register write
        // --------------------------------------------------------
        if (wr_en) begin
            unique case (addr)
                `OFS_PIN_CONFIG: r_nxt.pin_config = wdata;
                `OFS_PRESCALE:   r_nxt.prescale = wdata[4:0];
                `OFS_IRQ_ENABLE: r_nxt.irq_en = wdata[0];
                `OFS_CONTROL: begin
                    r_nxt.pseudo_idle_select = wdata[`CTL_PSEUDO_IDLE_SELECT_BIT];
                    r_nxt.enable = wdata[`CTL_ENABLE_BIT];
                    if (!wdata[`CTL_ENABLE_BIT]) begin
                        r_nxt.setup_cnt = 12'(`SETUP_CYCLES);
                    end
                    // Writing zero to the done bit clears it; a one leaves it as it is.
                    if (!wdata[`CTL_DONE_BIT]) begin
                        r_nxt.done = 1'b0;
                    end
                    // A pending start counts as busy, so a second write cannot retarget it.
                    if (r_r.state != conv_seq_pkg::ST_CONV && !r_r.start) begin
                        r_nxt.channel = wdata[`CTL_CH_HI:`CTL_CH_LO];
                        // A start on an unconfigured pin or in standby is dropped.
                        if (wdata[`CTL_START_BIT] && r_r.enable
                            && r_r.pin_config[wdata[`CTL_CH_HI:`CTL_CH_LO]]) begin
                            r_nxt.start = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------
        // Conversion sequence
        // --------------------------------------------------------
        unique case (r_r.state)
            conv_seq_pkg::ST_OFF: begin
                if (r_r.enable) begin
                    r_nxt.state = conv_seq_pkg::ST_IDLE;
                end
            end
            conv_seq_pkg::ST_IDLE: begin
                if (!r_r.enable) begin
                    r_nxt.state = conv_seq_pkg::ST_OFF;
                    r_nxt.start = 1'b0;
                    // A start waits for a tick so that the sample period is full length.
                end else if (r_r.start && tick) begin
                    r_nxt.state      = conv_seq_pkg::ST_CONV;
                    r_nxt.period_cnt = 4'h0;
                    r_nxt.shift      = 10'h200;
                    r_nxt.precision  = r_r.pseudo_idle_select;
                end
            end
            conv_seq_pkg::ST_CONV: begin
                // Dropping enable aborts the run and keeps the previous result.
                if (!r_r.enable) begin
                    r_nxt.state = conv_seq_pkg::ST_OFF;
                    r_nxt.start = 1'b0;
                end else if (tick) begin
                    r_nxt.period_cnt = r_r.period_cnt + 4'h1;
                    // Each tick closes one converter period.
                    // Period 0 is sample and hold; periods 1..10 resolve one bit each.
                    if (r_r.period_cnt != 4'h0) begin
                        if (!cmp_sync) begin
                            r_nxt.shift[4'hA - r_r.period_cnt] = 1'b0;
                        end
                        if (r_r.period_cnt != 4'hA) begin
                            r_nxt.shift[4'h9 - r_r.period_cnt] = 1'b1;
                        end
                    end
                    if (r_r.period_cnt == `CONV_PERIODS - 4'h1) begin
                        r_nxt.state  = conv_seq_pkg::ST_IDLE;
                        r_nxt.start  = 1'b0;
                        r_nxt.done   = 1'b1;
                        // Standard mode keeps only the upper eight bits.
                        r_nxt.result = r_r.precision ? r_nxt.shift
                                     : {r_nxt.shift[9:2], 2'b00};
                    end
                end
            end
            default: begin
                // The one unused state code falls back to standby.
                r_nxt.state = conv_seq_pkg::ST_OFF;
            end
        endcase

        // --------------------------------------------------------
        // Interrupt hold
        // --------------------------------------------------------
        // Requests during a precision run are latched and released afterwards.
        // Held requests show for one cycle after the run, so the controller must latch them.
        if (r_r.state == conv_seq_pkg::ST_CONV && r_r.precision) begin
            r_nxt.irq_hold = r_r.irq_hold | other_irq_in;
        end else begin
            r_nxt.irq_hold = 8'h00;
        end

        // --------------------------------------------------------
        // Synchronous reset
        // --------------------------------------------------------
        // Applied last so that it overrides every update above.
        if (srst) begin
            r_nxt            = '0;
            r_nxt.state      = conv_seq_pkg::ST_OFF;
            r_nxt.prescale   = `PRS_RESET;
            r_nxt.setup_cnt  = 12'(`SETUP_CYCLES);
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        r_r <= r_nxt;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Data outputs except other_irq_out come straight from registers, as does converter_powered; other_irq_out and the other flags are decoded.
    assign rdata             = r_r.rdata;
    assign analog_pin_enable = r_r.pin_config;
    assign mux_select        = r_r.channel;
    // The sample phase spans the whole first converter period.
    assign sample_hold       = (r_r.state == conv_seq_pkg::ST_CONV) && (r_r.period_cnt == 4'h0);
    assign trial_code        = r_r.shift;
    assign converter_powered = r_r.enable;
    // The halt ends when the run leaves ST_CONV, with the done flag or an abort, whatever irq_en holds.
    assign cpu_halt          = (r_r.state == conv_seq_pkg::ST_CONV) && r_r.precision;
    assign other_irq_out     = cpu_halt ? 8'h00 : (other_irq_in | r_r.irq_hold);
    assign conversion_irq    = r_r.done && r_r.irq_en;
    assign setup_ready       = r_r.enable && (r_r.setup_cnt == 12'h000);

endmodule : conv_seq
`default_nettype wire

// ===== bench/conv_seq_asserts.sv
// Port checker for the conversion sequencer.
// Assumes it is bound onto conv_seq and that clk is the only clock.
`timescale 1ns/1ps
`default_nettype none
module conv_seq_asserts (
    // Clock, reset and register port
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    // Converter and CPU side
    input wire logic [7:0] analog_pin_enable,
    input wire logic [2:0] mux_select,
    input wire logic       sample_hold,
    input wire logic       converter_powered,
    input wire logic [7:0] other_irq_out,
    input wire logic       cpu_halt,
    input wire logic       conversion_irq
);
    logic [4:0]  prs_r;
    logic [11:0] cnt_r;
    logic [11:0] len_w;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Cycles since the sample phase began, judged against the prescaled length.
    always_ff @(posedge clk) begin
        if (srst) begin
            prs_r <= 5'h00;
            cnt_r <= 12'h000;
        end else begin
            if (wr_en && addr == 3'h2) prs_r <= wdata[4:0];
            cnt_r <= $rose(sample_hold) ? 12'h001 : cnt_r + 12'h001;
        end
    end
    assign len_w = 12'h02C * ({7'h00, prs_r} + 12'h001);
    sequence s_hold; sample_hold [*4]; endsequence
    property p_pin; wr_en && addr == 3'h0 |=> analog_pin_enable == $past(wdata); endproperty
    a_pin: assert property (p_pin) else $error("pin enables not updated");
    property p_smp; $rose(sample_hold) |-> s_hold; endproperty
    a_smp: assert property (p_smp) else $error("sample phase too short");
    property p_chan; $rose(sample_hold) |-> analog_pin_enable[mux_select]; endproperty
    a_chan: assert property (p_chan) else $error("digital pin converted");
    property p_len; $rose(conversion_irq) && !$past(wr_en) |-> cnt_r >= len_w - 12'h002
        && cnt_r <= len_w + 12'h004; endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");
    property p_halt; cpu_halt |-> other_irq_out == 8'h00; endproperty
    a_halt: assert property (p_halt) else $error("request passed while halted");
    property p_stby; !converter_powered |=> !cpu_halt && !sample_hold; endproperty
    a_stby: assert property (p_stby) else $error("activity in standby");
    property p_irq; conversion_irq && !wr_en |=> conversion_irq; endproperty
    a_irq: assert property (p_irq) else $error("done request dropped alone");
    property p_rd; !$past(rd_en) |-> rdata == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("read data outside slot");
endmodule : conv_seq_asserts
`default_nettype wire

// ===== bench/analog_front_model.sv
// Analog front end: one level per input and a comparator against the trial code.
// Assumes the sequencer drives mux_select and trial_code directly.
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
    // Sequencer side
    input  wire logic        clk,
    input  wire logic [7:0]  analog_pin_enable,
    input  wire logic [2:0]  mux_select,
    input  wire logic [9:0]  trial_code,
    output logic             comparator_in,
    // Bench side
    input  wire logic [79:0] levels
);
    logic flick_r = 1'b0;
    always @(posedge clk) flick_r <= ~flick_r;
    // A pin left digital feeds no level, so the comparator flickers instead.
    assign comparator_in = analog_pin_enable[mux_select] ?
        (levels[mux_select*10 +: 10] >= trial_code) : flick_r;
endmodule : analog_front_model
`default_nettype wire

// ===== bench/adc_conversion_sequencer_test.sv
// Self-checking bench for the conversion sequencer.
// Assumes conv_seq, its checker and the analog model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_test;
    logic clk = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rd_pend = 1'b0;
    logic [2:0] addr = 3'h0, mux_select;
    logic [7:0] wdata = 8'h00, other_irq_in = 8'h00, rdata, analog_pin_enable, other_irq_out;
    logic [9:0] trial_code;
    logic [79:0] levels = 80'h0;
    logic sample_hold, comparator_in, converter_powered, cpu_halt, conversion_irq, setup_ready;
    logic [7:0] exp_q[$];
    int fail_count = 0, n_tests = 0, seed = 32'h43AB0D71, i, k;
    always #4 clk = ~clk;
    conv_seq i_dut (.clk, .srst, .addr, .wdata, .wr_en, .rd_en, .rdata, .analog_pin_enable,
        .mux_select, .sample_hold, .trial_code, .comparator_in, .converter_powered,
        .other_irq_in, .other_irq_out, .cpu_halt, .conversion_irq, .setup_ready);
    analog_front_model i_afe (.clk, .analog_pin_enable, .mux_select, .trial_code,
        .comparator_in, .levels);
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    // Read data stands one cycle, so the note taken at the read is checked one edge later.
    always @(posedge clk) begin
        if (rd_pend) chk(rdata, exp_q.pop_front());
        rd_pend <= rd_en;
    end
    task automatic bus(input logic w, r, input logic [2:0] a, input logic [7:0] d);
        wr_en <= w;
        rd_en <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask : rd
    task automatic idle(input int n);
        bus(1'b0, 1'b0, 3'h0, 8'h00);
        repeat (n) @(posedge clk);
    endtask : idle
    task automatic convert(input logic [2:0] ch, input logic prec, input logic [4:0] p);
        logic [9:0] lv;
        logic [7:0] req;
        lv = levels[ch*10 +: 10];
        req = 8'($random(seed)) | 8'h01;
        bus(1'b1, 1'b0, 3'h2, {3'h0, p});
        bus(1'b1, 1'b0, 3'h1, {1'b0, prec, 6'h28} | {5'h00, ch});
        bus(1'b1, 1'b0, 3'h1, {1'b0, prec, 6'h28} | {5'h00, ~ch});
        other_irq_in <= req;
        idle(10);
        chk(mux_select, {5'h00, ch});
        chk({7'h00, cpu_halt}, {7'h00, prec});
        if (prec) chk(other_irq_out, 8'h00);
        // Dropping the request mid-run shows whether it was held.
        other_irq_in <= 8'h00;
        k = 0;
        while (conversion_irq !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        if (k == 2000) begin
            fail_count++;
            complete_run();
        end
        chk(other_irq_out, prec ? req : 8'h00);
        rd(3'h1, {1'b0, prec, 6'h30} | {5'h00, ch});
        rd(3'h3, lv[9:2]);
        rd(3'h4, prec ? {6'h00, lv[1:0]} : 8'h00);
        bus(1'b1, 1'b0, 3'h1, {1'b0, prec, 6'h20} | {5'h00, ch});
        idle(2);
        chk({7'h00, conversion_irq}, 8'h00);
        $display("conversion on input %0d done", ch);
    endtask : convert
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        for (i = 0; i < 8; i++) levels[i*10 +: 10] = 10'($random(seed));
        levels[79:70] = 10'h3FF;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 7; i++) rd(i[2:0], 8'h00);
        bus(1'b1, 1'b0, 3'h0, 8'h7F);
        bus(1'b1, 1'b0, 3'h1, 8'h20);
        bus(1'b1, 1'b0, 3'h5, 8'h01);
        rd(3'h0, 8'h7F);
        idle(1);
        chk(analog_pin_enable, 8'h7F);
        for (k = 0; k < 600 && setup_ready !== 1'b1; k++) @(posedge clk);
        if (k == 600) begin
            fail_count++;
            complete_run();
        end
        $display("register and setup test done");
        bus(1'b1, 1'b0, 3'h1, 8'h2F);
        idle(120);
        chk({7'h00, conversion_irq}, 8'h00);
        rd(3'h1, 8'h27);
        $display("digital pin refusal test done");
        bus(1'b1, 1'b0, 3'h0, 8'hFF);
        for (i = 0; i < 8; i++) convert(i[2:0], i[0], {4'h0, i[1]});
        bus(1'b1, 1'b0, 3'h5, 8'h00);
        bus(1'b1, 1'b0, 3'h1, 8'h2B);
        idle(120);
        chk({7'h00, conversion_irq}, 8'h00);
        rd(3'h1, 8'h33);
        bus(1'b1, 1'b0, 3'h1, 8'h23);
        bus(1'b1, 1'b0, 3'h5, 8'h01);
        $display("polled completion test done");
        bus(1'b1, 1'b0, 3'h1, 8'h2B);
        idle(10);
        bus(1'b1, 1'b0, 3'h1, 8'h03);
        bus(1'b1, 1'b0, 3'h1, 8'h0B);
        idle(120);
        chk({7'h00, converter_powered}, 8'h00);
        chk({7'h00, conversion_irq}, 8'h00);
        rd(3'h1, 8'h03);
        idle(3);
        $display("standby test done");
        complete_run();
    end
endmodule : adc_conversion_sequencer_test
bind conv_seq conv_seq_asserts i_chk (.clk, .srst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .analog_pin_enable, .mux_select, .sample_hold, .converter_powered, .other_irq_out,
    .cpu_halt, .conversion_irq);
`default_nettype wire
